// *** src/sc_irq_dio.sv ***
// Interrupt status, activation mirror and direct contact access registers
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "sc_irq_dio_params.svh"

module sc_irq_dio (
	// Clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_sys_rst,
	// Register port
	input  wire sc_irq_dio_pkg::reg_addr_t i_addr,
	input  wire sc_irq_dio_pkg::reg_word_t i_wdata,
	input  wire logic                      i_wr,
	input  wire logic                      i_rd,
	output logic [15:0]                    o_rdata,
	// Interrupt sources from the rest of the interface
	input  wire sc_irq_dio_pkg::irq_vec_t  i_irq_evt,
	output logic                           o_combined_irq,
	// Hardware activation sequencer
	input  wire logic                      i_seq_update,
	input  wire sc_irq_dio_pkg::act_ctl_t  i_seq_ctl,
	input  wire logic                      i_deact_busy,
	output logic                           o_auto_activation_go,
	// Normal transmit path and receiver
	input  wire logic                      i_gen_clk,
	input  wire logic                      i_tx_io,
	input  wire logic                      i_tx_io_drive,
	input  wire logic                      i_rx_char_valid,
	output logic                           o_rx_fifo_push,
	// Card contacts
	input  wire logic                      i_card_detect,
	input  wire logic                      i_card_clk,
	input  wire logic                      i_card_io,
	output logic                           o_card_clk,
	output logic                           o_card_clk_oe,
	output logic                           o_card_io,
	output logic                           o_card_io_oe,
	output logic                           o_card_power,
	output logic                           o_card_reset_out_n,
	output logic                           o_function_code_out,
	output logic                           o_card_clk_buf_en,
	output logic                           o_card_io_buf_en
);
	import sc_irq_dio_pkg::*;

	irq_vec_t  raw_r;
	irq_vec_t  raw_nxt;
	irq_vec_t  irq_mask_r;
	irq_vec_t  clr_vec;
	act_ctl_t  act_r;
	ovr_t      ovr_r;
	logic      sync_en_r;
	logic      go_r;
	reg_word_t rdata_r;
	reg_word_t rdata_nxt;
	logic      wr_clr;
	logic      wr_act;
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic      clk_pin_nxt;
	logic      clk_oe_nxt;
	logic      io_oe_nxt;
	logic      rst_n_nxt;
	logic      fcb_nxt;
	logic      clk_buf_nxt;
	logic      io_buf_nxt;

	// Write strobe for one register index
	function automatic logic wr_hit(input logic wr, input reg_addr_t a, input reg_addr_t idx);
		wr_hit = wr && (a == idx);
	endfunction : wr_hit

	assign wr_clr = wr_hit(i_wr, i_addr, `IRQ_CLEAR_IDX);
	assign wr_act = wr_hit(i_wr, i_addr, `CARD_ACT_CTL_IDX);

	// Only 12:0 can be cleared; tide bits are levels with no clear
	always_comb begin
		clr_vec = '0;
		if (wr_clr) begin
			clr_vec[`IRQ_CLR_TOP:0] = i_wdata[`IRQ_CLR_TOP:0];
		end
	end

	// Event ORed in after the clear, so a coincident event survives
	always_comb begin
		raw_nxt = (raw_r & ~clr_vec) | i_irq_evt;
		raw_nxt[14:13] = i_irq_evt[14:13];
	end

	// Raw status, set only by hardware events; bits 12:0 cleared through the clear register, tide bits follow their sources
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			raw_r <= '0;
		end else begin
			raw_r <= raw_nxt;
		end
	end

	// Mask register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			irq_mask_r <= `IRQ_MASK_RST;
		end else if (wr_hit(i_wr, i_addr, `IRQ_MASK_IDX)) begin
			irq_mask_r <= i_wdata[14:0];
		end
	end

	// Combinational level from the raw and mask flops, with no output flop
	assign o_combined_irq = |(raw_r & irq_mask_r);

	// Activation control: sequencer wins, software locked out in deactivation
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			act_r <= `ACT_RST_VAL;
		end else if (i_seq_update) begin
			act_r <= i_seq_ctl;
		end else if (wr_act && !i_deact_busy) begin
			act_r <= i_wdata[4:0];
		end
	end

	// Override values for direct contact drive
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ovr_r <= `OVR_RST_VAL;
		end else if (wr_hit(i_wr, i_addr, `DIRECT_OVR_IDX)) begin
			ovr_r <= i_wdata[5:0];
		end
	end

	// Control one: sync mode enable and a one-cycle auto_activation_go pulse
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sync_en_r <= 1'b0;
			go_r      <= 1'b0;
		end else begin
			go_r <= wr_hit(i_wr, i_addr, `CONTROL_ONE_IDX) && i_wdata[`CR1_GO_BIT];
			if (wr_hit(i_wr, i_addr, `CONTROL_ONE_IDX)) begin
				sync_en_r <= i_wdata[`CR1_SYNC_BIT];
			end
		end
	end

	assign o_auto_activation_go = go_r;

	// Two-stage synchronisers for detect, card clock and card I/O
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {i_card_detect, i_card_clk, i_card_io};
			sync2_r <= sync1_r;
		end
	end

	// Contact drive selection, normal or sync override
	always_comb begin
		clk_oe_nxt  = act_r[`ACT_PWR_BIT];
		if (sync_en_r) begin
			clk_pin_nxt = ovr_r[`OVR_CLK_BIT];
			io_oe_nxt   = !ovr_r[`OVR_IO_BIT];
			rst_n_nxt   = ovr_r[`OVR_RST_BIT];
			fcb_nxt     = ovr_r[`OVR_FCB_BIT];
			clk_buf_nxt = act_r[`ACT_CLK_ENABLE_CTL_BIT] && ovr_r[`OVR_CLK_ENABLE_CTL_BIT];
			io_buf_nxt  = act_r[`ACT_IOEN_BIT] && ovr_r[`OVR_IOEN_BIT];
		end else begin
			clk_pin_nxt = act_r[`ACT_CLK_ENABLE_CTL_BIT] && i_gen_clk;
			io_oe_nxt   = !act_r[`ACT_IOEN_BIT] || (i_tx_io_drive && !i_tx_io);
			rst_n_nxt   = act_r[`ACT_RST_BIT];
			fcb_nxt     = act_r[`ACT_FCB_BIT];
			clk_buf_nxt = act_r[`ACT_CLK_ENABLE_CTL_BIT];
			io_buf_nxt  = act_r[`ACT_IOEN_BIT];
		end
	end

	// Pin outputs from flops; I/O is open drain so its data is always low
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_card_clk          <= 1'b0;
			o_card_clk_oe       <= 1'b0;
			o_card_io_oe        <= 1'b0;
			o_card_power        <= 1'b0;
			o_card_reset_out_n  <= 1'b0;
			o_function_code_out <= 1'b0;
			o_card_clk_buf_en   <= 1'b0;
			o_card_io_buf_en    <= 1'b0;
		end else begin
			o_card_clk          <= clk_pin_nxt;
			o_card_clk_oe       <= clk_oe_nxt;
			o_card_io_oe        <= io_oe_nxt;
			o_card_power        <= act_r[`ACT_PWR_BIT];
			o_card_reset_out_n  <= rst_n_nxt;
			o_function_code_out <= fcb_nxt;
			o_card_clk_buf_en   <= clk_buf_nxt;
			o_card_io_buf_en    <= io_buf_nxt;
		end
	end

	assign o_card_io = 1'b0;

	// Receiver output is blocked in sync operation
	assign o_rx_fifo_push = i_rx_char_valid && !sync_en_r;

	// Read multiplexer, reserved and unmapped bits zero
	always_comb begin
		rdata_nxt = `REG_ZERO;
		if (i_rd) begin
			case (i_addr)
				`RAW_IRQ_STATUS_IDX:    rdata_nxt[14:0] = raw_r;
				`IRQ_MASK_IDX:          rdata_nxt[14:0] = irq_mask_r;
				`MASKED_IRQ_STATUS_IDX: rdata_nxt[14:0] = raw_r & irq_mask_r;
				`CARD_ACT_CTL_IDX: begin
					rdata_nxt[10:0] = {sync2_r[2], !o_card_io_buf_en, !o_card_io_oe,
						o_card_clk, !o_card_clk_buf_en, !o_card_clk_oe, act_r};
				end
				`DIRECT_OVR_IDX:        rdata_nxt[5:0] = ovr_r;
				`DIRECT_SAMPLE_IDX:     rdata_nxt[1:0] = sync2_r[1:0];
				`CONTROL_ONE_IDX:       rdata_nxt[0] = sync_en_r;
				default:                rdata_nxt = `REG_ZERO;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rdata_r <= `REG_ZERO;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;

	// Checks on the logic above
	raw_sticky_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(wr_clr && i_wdata[0] && i_irq_evt[0]) |=> raw_r[0])
		else $error("raw bit lost when event met clear");

	raw_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(wr_clr && i_wdata[3] && !i_irq_evt[3]) |=> !raw_r[3])
		else $error("raw bit not cleared by write of one");

	raw_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(raw_r[12] && !i_irq_evt[12] && !(wr_clr && i_wdata[12])) |=> raw_r[12])
		else $error("raw bit dropped without clear");

	masked_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_rd && i_addr == `MASKED_IRQ_STATUS_IDX) |=>
		o_rdata == {1'b0, $past(raw_r) & $past(irq_mask_r)})
		else $error("masked status read wrong");

	mask_block_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(irq_mask_r == 15'h0000) |-> !o_combined_irq)
		else $error("interrupt out with all masks clear");

	mask_reset_a: assert property (@(posedge i_clk)
		$past(i_sys_rst) |-> irq_mask_r == 15'h0000)
		else $error("mask not zero after reset");

	deact_lock_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(wr_act && i_deact_busy && !i_seq_update) |=> $stable(act_r))
		else $error("activation write taken during deactivation");

	sync_clk_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		sync_en_r |=> o_card_clk == $past(ovr_r[1]))
		else $error("card clock not from override");

	sync_io_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(sync_en_r && !ovr_r[0]) |=> o_card_io_oe)
		else $error("io not pulled low by override");

	sync_reset_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		sync_en_r |=> o_card_reset_out_n == $past(ovr_r[4]))
		else $error("card reset not from override");

	sync_bufen_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(sync_en_r && !ovr_r[3]) |=> !o_card_clk_buf_en)
		else $error("clock buffer enable not forced low");

	fifo_block_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		sync_en_r |-> !o_rx_fifo_push)
		else $error("receive push in sync mode");

	sample_path_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_rd && i_addr == `DIRECT_SAMPLE_IDX) |=> o_rdata[15:2] == 14'h0000)
		else $error("sample register upper bits not zero");

	read_window_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_rd |=> o_rdata == 16'h0000)
		else $error("read data outside its cycle");

	raw_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_wr && i_addr == `RAW_IRQ_STATUS_IDX && i_irq_evt == 15'h0000) |=>
		raw_r == {2'b00, $past(raw_r[12:0])})
		else $error("raw status changed by a write");

	tide_level_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		1'b1 |=> raw_r[14:13] == $past(i_irq_evt[14:13]))
		else $error("tide bits do not follow their sources");

	raw_set_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_irq_evt[12:0] != 13'h0000) |=>
		(raw_r[12:0] & $past(i_irq_evt[12:0])) == $past(i_irq_evt[12:0]))
		else $error("event did not set its raw bit");

	raw_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_rd && i_addr == `RAW_IRQ_STATUS_IDX) |=> o_rdata == {1'b0, $past(raw_r)})
		else $error("raw status read wrong");

	masked_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_wr && i_addr == `MASKED_IRQ_STATUS_IDX) |=> $stable(irq_mask_r))
		else $error("masked status write took effect");

	clear_mask_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(wr_clr && i_irq_evt[12:0] == 13'h0000) |=>
		raw_r[12:0] == ($past(raw_r[12:0]) & ~$past(i_wdata[12:0])))
		else $error("clear did not act bit by bit");

	clear_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_rd && i_addr == `IRQ_CLEAR_IDX) |=> o_rdata == 16'h0000)
		else $error("clear register read not zero");

	tide_noclear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(wr_clr && i_wdata[14:13] == 2'b11) |=> raw_r[14:13] == $past(i_irq_evt[14:13]))
		else $error("tide bit touched by clear");

	seq_load_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_seq_update |=> act_r == $past(i_seq_ctl))
		else $error("sequencer value not mirrored");

	act_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(wr_act && !i_deact_busy && !i_seq_update) |=> act_r == $past(i_wdata[4:0]))
		else $error("activation write lost");

	mirror_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_rd && i_addr == `CARD_ACT_CTL_IDX) |=>
		(o_rdata[10] == $past(sync2_r[2])) && (o_rdata[5] == !$past(o_card_clk_oe)))
		else $error("activation mirror bits wrong");

	act_upper_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_rd && i_addr == `CARD_ACT_CTL_IDX) |=> o_rdata[15:11] == 5'h00)
		else $error("activation upper bits not zero");

	ovr_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_rd && i_addr == `DIRECT_OVR_IDX) |=> o_rdata == {10'h000, $past(ovr_r)})
		else $error("override read wrong");

	sample_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_rd && i_addr == `DIRECT_SAMPLE_IDX) |=> o_rdata[1:0] == $past(sync2_r[1:0]))
		else $error("sample bits not the synced lines");

	mask_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_wr && i_addr == `IRQ_MASK_IDX) |=> irq_mask_r == $past(i_wdata[14:0]))
		else $error("mask write lost");

	irq_level_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(|(raw_r & irq_mask_r)) |-> o_combined_irq)
		else $error("enabled interrupt not on combined output");

	sync_fcb_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		sync_en_r |=> o_function_code_out == $past(ovr_r[5]))
		else $error("function code not from override");

	sync_iobuf_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(sync_en_r && !ovr_r[2]) |=> !o_card_io_buf_en)
		else $error("data buffer enable not forced low");

	norm_io_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(!sync_en_r && !act_r[`ACT_IOEN_BIT]) |=> o_card_io_oe)
		else $error("data not forced low with enable clear");

	norm_clk_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(!sync_en_r && !act_r[`ACT_CLK_ENABLE_CTL_BIT]) |=> !o_card_clk)
		else $error("card clock not forced low");

	power_pin_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		1'b1 |=> o_card_power == $past(act_r[`ACT_PWR_BIT]))
		else $error("supply pin not from power bit");

	fifo_pass_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(!sync_en_r && i_rx_char_valid) |-> o_rx_fifo_push)
		else $error("receive push lost in normal mode");

endmodule : sc_irq_dio

// *** src/sc_irq_dio_params.svh ***
// Constants of the smart card interrupt status and direct contact register block
// Behaviour
// - Raw status reads each source unmasked, bit 15 reads zero, writes ignored.
// - Raw bits: 14 tx tide down to 0 card inserted, fixed order.
// - Masked status uses raw layout, raw gated by mask, writes ignored.
// - Clear register is write-only; a 1 clears that pending bit, 0 nothing.
// - Clear bits exist only at 12:0; tide bits have no clear.
// - Activation mirror bits follow hardware during activation, deactivation, warm reset.
// - Deactivation is hardware only; activation writes during deactivation are ignored.
// - Activation bits 10:5 are read-only mirrors of contact control lines.
// - Activation bits 4:0 read/write: function code, data, clock, reset, supply.
// - Sync mode: function code follows override bit 5, reset follows bit 4.
// - Sync mode: override bits 3 and 2 at 0 force buffer enables low.
// - Sync mode: card clock from override bit 1; bit 0 at 0 pulls I/O low.
// - Sample register returns synchronised card clock in bit 1, I/O in bit 0.
// - In sync operation received bits never enter the receive FIFO.
// - Reserved upper bits of activation, override and sample registers read zero.
// - Mask bit 1 passes its interrupt, 0 blocks it; masks reset to 0.
// - One active-high combined interrupt is the OR of fifteen masked interrupts.
`ifndef SC_IRQ_DIO_PARAMS_SVH
`define SC_IRQ_DIO_PARAMS_SVH

// Register indices on the plain port
`define RAW_IRQ_STATUS_IDX    3'h0
`define IRQ_MASK_IDX          3'h1
`define MASKED_IRQ_STATUS_IDX 3'h2
`define IRQ_CLEAR_IDX         3'h3
`define CARD_ACT_CTL_IDX      3'h4
`define DIRECT_OVR_IDX        3'h5
`define DIRECT_SAMPLE_IDX     3'h6
`define CONTROL_ONE_IDX       3'h7

// Field positions
`define IRQ_NUM               15
`define IRQ_CLR_TOP           12
`define ACT_RW_W              5
`define OVR_W                 6
`define OVR_FCB_BIT           5
`define OVR_RST_BIT           4
`define OVR_CLK_ENABLE_CTL_BIT         3
`define OVR_IOEN_BIT          2
`define OVR_CLK_BIT           1
`define OVR_IO_BIT            0
`define ACT_FCB_BIT           4
`define ACT_IOEN_BIT          3
`define ACT_CLK_ENABLE_CTL_BIT         2
`define ACT_RST_BIT           1
`define ACT_PWR_BIT           0
`define CR1_SYNC_BIT          0
`define CR1_GO_BIT            1

// Reset values
`define IRQ_MASK_RST          15'h0000
`define ACT_RST_VAL           5'h00
`define OVR_RST_VAL           6'h00
`define REG_ZERO              16'h0000

`endif

// *** src/sc_irq_dio_pkg.sv ***
// Types shared by the smart card interrupt status and direct contact block
package sc_irq_dio_pkg;
	typedef logic [15:0] reg_word_t;
	typedef logic [2:0]  reg_addr_t;
	typedef logic [14:0] irq_vec_t;
	typedef logic [4:0]  act_ctl_t;
	typedef logic [5:0]  ovr_t;
endpackage : sc_irq_dio_pkg

// *** tb/sc_card_model.sv ***
// Behavioural smart card seen through the reader contacts
`timescale 1ns/1ps

module sc_card_model (
	// Reader side of the contacts
	input  wire logic i_clk_pin,
	input  wire logic i_clk_oe,
	input  wire logic i_io_pull,
	input  wire logic i_power,
	// Commands from the bench
	input  wire logic i_present,
	input  wire logic i_io_bit,
	// Line levels back to the reader
	output logic      o_clk_line,
	output logic      o_io_line,
	output logic      o_detect
);
	// Clock line has a pull-down, so a released clock reads low
	assign o_clk_line = i_clk_oe & i_clk_pin;
	// Open-drain I/O with pull-up; an unpowered card never pulls
	assign o_io_line = ~i_io_pull & ~(i_power & ~i_io_bit);
	// Detect switch closes while a card sits in the slot
	assign o_detect = i_present;
endmodule : sc_card_model

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt status and direct contact registers
`timescale 1ns/1ps

module testbench;
	import sc_irq_dio_pkg::*;
	logic      clk, rst, wr, rd, seq_upd, deact, gen_clk, rx_valid, present, card_bit;
	logic      clk_w, io_w, detect, cclk, cclk_oe, cio, cio_oe, pwr, rst_n;
	logic      fco, cbuf, iobuf, go, irq, push;
	reg_addr_t addr;
	reg_word_t wdata, v;
	logic [15:0] rdata;
	irq_vec_t  evt, raw_m, mask_m;
	act_ctl_t  seq_ctl;
	logic [1:0] tide;
	int        num_errors, checked, k, n;

	sc_irq_dio sc_irq_dio_inst (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_irq_evt(evt), .o_combined_irq(irq),
		.i_seq_update(seq_upd), .i_seq_ctl(seq_ctl), .i_deact_busy(deact),
		.o_auto_activation_go(go), .i_gen_clk(gen_clk), .i_tx_io(1'b0),
		.i_tx_io_drive(1'b0), .i_rx_char_valid(rx_valid), .o_rx_fifo_push(push),
		.i_card_detect(detect), .i_card_clk(clk_w), .i_card_io(io_w), .o_card_clk(cclk),
		.o_card_clk_oe(cclk_oe), .o_card_io(cio), .o_card_io_oe(cio_oe), .o_card_power(pwr),
		.o_card_reset_out_n(rst_n), .o_function_code_out(fco), .o_card_clk_buf_en(cbuf),
		.o_card_io_buf_en(iobuf));

	sc_card_model sc_card_model_inst (.i_clk_pin(cclk), .i_clk_oe(cclk_oe), .i_io_pull(cio_oe),
		.i_power(pwr), .i_present(present), .i_io_bit(card_bit), .o_clk_line(clk_w),
		.o_io_line(io_w), .o_detect(detect));

	// Expected raw status: tide bits are levels, the rest sticky
	function automatic reg_word_t raw_exp(input irq_vec_t r, input logic [1:0] t);
		return {1'b0, t, r[12:0]};
	endfunction : raw_exp

	// Expected sample word while the card is powered in sync mode
	function automatic reg_word_t sample_exp(input reg_word_t o, input logic b);
		return {14'h0, o[1], o[0] & b};
	endfunction : sample_exp

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr_reg(input reg_addr_t a, input reg_word_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input string name, input reg_addr_t a, input reg_word_t e,
		input reg_word_t m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(name, e & m, rdata & m);
	endtask : rd_reg

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Divider clock for normal mode, its edges falling on falling edges of the system clock
	initial begin
		gen_clk = 1'b0;
		forever #40 gen_clk = ~gen_clk;
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		complete_run();
	end

	initial begin
		{rst, wr, rd, seq_upd, deact, rx_valid, present, card_bit} = 8'h81;
		{addr, wdata, evt, seq_ctl, raw_m, num_errors, checked} = '0;
		void'($urandom(32'hCEF635A4));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check("reset pin at reset", 16'h0, {15'h0, rst_n});
		rd_reg("raw at reset", 3'h0, 16'h0, 16'hFFFF);
		rd_reg("mask at reset", 3'h1, 16'h0, 16'hFFFF);
		rd_reg("override at reset", 3'h5, 16'h0, 16'hFFFF);
		rd_reg("act at reset", 3'h4, 16'h0, 16'hF81F);
		$display("reset test done");
		// Random events, masks and clears, all ones mask first
		for (k = 0; k < 20; k++) begin
			v = reg_word_t'($urandom);
			tide = v[14:13];
			mask_m = (k == 0) ? 15'h7FFF : irq_vec_t'($urandom);
			wr_reg(3'h1, {1'b0, mask_m});
			@(posedge clk);
			evt <= {tide, v[12:0]};
			@(posedge clk);
			evt <= {tide, 13'h0};
			raw_m = raw_m | {2'b0, v[12:0]};
			wr_reg(3'h0, ~v);
			wr_reg(3'h2, ~v);
			rd_reg("raw status", 3'h0, raw_exp(raw_m, tide), 16'hFFFF);
			rd_reg("masked status", 3'h2, raw_exp(raw_m, tide) & mask_m, 16'hFFFF);
			check("combined irq", |(raw_exp(raw_m, tide) & mask_m), irq);
			v = reg_word_t'($urandom);
			wr_reg(3'h3, v);
			raw_m = raw_m & ~{2'b0, v[12:0]};
			rd_reg("raw after clear", 3'h0, raw_exp(raw_m, tide), 16'hFFFF);
			rd_reg("clear readback", 3'h3, 16'h0, 16'hFFFF);
		end
		// Clear and event in one cycle on every clearable bit
		for (k = 0; k < 13; k++) begin
			@(posedge clk);
			addr <= 3'h3;
			wdata <= 16'h1 << k;
			wr <= 1'b1;
			evt <= 15'h1 << k;
			@(posedge clk);
			wr <= 1'b0;
			evt <= '0;
			rd_reg("set beats clear", 3'h0, 16'h1 << k, 16'h1 << k);
		end
		wr_reg(3'h3, 16'h1FFF);
		$display("interrupt test done");
		for (k = 0; k < 8; k++) begin
			v = reg_word_t'($urandom);
			present <= v[5];
			repeat (4) @(posedge clk);
			wr_reg(3'h4, v);
			repeat (4) @(posedge clk);
			#1;
			check("power pin", v[0], pwr);
			check("reset pin", v[1], rst_n);
			rd_reg("act control", 3'h4, {5'h0, v[5], ~v[3], v[3], 1'b0, ~v[2], ~v[0], v[4:0]},
				16'hFF7F);
			@(posedge clk);
			deact <= 1'b1;
			wr_reg(3'h4, ~v);
			deact <= 1'b0;
			rd_reg("act during deactivation", 3'h4, v, 16'h001F);
			@(posedge clk);
			seq_upd <= 1'b1;
			seq_ctl <= v[10:6];
			wr_reg(3'h4, v);
			seq_upd <= 1'b0;
			rd_reg("act from sequencer", 3'h4, {11'h0, v[10:6]}, 16'h001F);
		end
		// Clock enable low must hold the card clock low
		wr_reg(3'h4, 16'h001B);
		repeat (2) @(posedge clk);
		n = 0;
		// Sample once the edge has settled, never in its own time step
		repeat (24) begin
			@(posedge clk);
			#1;
			n += cclk;
		end
		check("clock held low", 16'h0, 16'(n));
		wr_reg(3'h4, 16'h001F);
		repeat (2) @(posedge clk);
		n = 0;
		repeat (24) begin
			@(posedge clk);
			#1;
			n += cclk;
		end
		check("clock running", 16'h1, {15'h0, n != 0});
		$display("activation test done");
		@(posedge clk);
		addr <= 3'h7;
		wdata <= 16'h0002;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rx_valid <= 1'b1;
		#1;
		check("auto_activation_go pulse", 16'h1, {15'h0, go});
		check("push in normal mode", 16'h1, {15'h0, push});
		@(posedge clk);
		#1;
		check("auto_activation_go pulse ends", 16'h0, {15'h0, go});
		wr_reg(3'h7, 16'h0001);
		for (k = 0; k < 12; k++) begin
			v = reg_word_t'($urandom);
			@(posedge clk);
			card_bit <= v[6];
			rx_valid <= v[7];
			wr_reg(3'h5, v);
			repeat (8) @(posedge clk);
			#1;
			check("function code", v[5], fco);
			check("reset override", v[4], rst_n);
			check("clock buffer", v[3], cbuf);
			check("io buffer", v[2], iobuf);
			check("card clock", v[1], cclk);
			check("io pull low", {15'h0, !v[0]}, cio_oe);
			check("io data and clock enable", 16'h1, {14'h0, cio, cclk_oe});
			check("push in sync mode", 16'h0, {15'h0, push});
			rd_reg("override", 3'h5, {10'h0, v[5:0]}, 16'hFFFF);
			rd_reg("sample", 3'h6, sample_exp(v, v[6]), 16'hFFFF);
		end
		$display("direct contact test done");
		complete_run();
	end
endmodule : testbench
